//--- hw/dither_dac_regs.svh
`ifndef DITHER_DAC_REGS_SVH
`define DITHER_DAC_REGS_SVH
// register offsets (byte addresses)
`define OFS_CTRL        4'h0
`define OFS_TARGET      4'h4
`define OFS_APPLIED     4'h8
`define OFS_MEASURED    4'hC
// control fields
`define CTRL_MODE_LSB   0
`define CTRL_PRINT_BIT  2
// reset values and limits
`define CODE_MAX        12'h0FF0
`define CODE_MIN        12'h0000
`define DUTY_MAX        8'hFF
`define TARGET_RST      12'h0000
// timing (10 ns clock)
`define CLK_NS          10
`define PWM_PERIOD_NS   16000
`define PWM_SLOT_CYC    (`PWM_PERIOD_NS / `CLK_NS / 256)
`define BAUD_BPS        115200
`define BAUD_CYC        (1000000000 / `BAUD_BPS / `CLK_NS)
`define CLOSED_SAMPLES  256
`define OPEN_SAMPLES    16
`define SWEEP_HOLD      256
`endif

//--- hw/dither_dac_pkg.sv
package dither_dac_pkg;
    typedef enum logic [1:0] {MODE_IDLE, MODE_CLOSED, MODE_OPEN, MODE_SWEEP} mode_t;
    typedef enum {TX_IDLE, TX_CHAR, TX_SEP} tx_state_t;
endpackage

//--- hw/dither_dac.sv
`timescale 1ns/1ps
`include "dither_dac_regs.svh"

// Behaviour
// - target codes above 0xFF0 are clamped to 0xFF0 on write.
// - duty never exceeds 255/256; pin is low in the last slot.
// - closed loop sums 256 ten-bit samples, rounds to 12 bits per interval.
// - measured equal to target leaves applied code unchanged.
// - measured below target raises applied code by one step.
// - measured above target lowers applied code by one step.
// - a 16-entry duty table is rebuilt and one entry loaded per period.
// - at 0xFF0 an increase is ignored; base 0xFF, no dither.
// - upper eight bits pick the lower duty; 0xFEx alternates 0xFE/0xFF.
// - at 0x000 a decrease is ignored; 0x00x alternates 0x00/0x01.
// - open loop applies no correction, reports 16-sample sums scaled, lines at 64 Hz.
// - open and closed loop monitoring sessions first send the target code; sweep does not.
// - values go as hex chars plus comma or line feed at 115.2 kbps.
// - sweep steps undithered duty 0x00 to 0xFF, 256 conversions each.
// - sweep reports unscaled 16-sample sums as four hex characters.
// - sixteen dither patterns; pattern zero adds nothing.
// - dither table advances every 15.36 us PWM period (256 slots of 6 cycles).
module dither_dac
    import dither_dac_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // register port
    input  wire logic [3:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    // feedback converter
    input  wire logic [9:0]  filtered_feedback_input_i,
    input  wire logic        sample_valid_i,
    // outputs
    output logic             pwm_output_pin_o,
    output logic             monitor_serial_port_o
);
    typedef struct packed {
        logic [31:0] rdata;
        logic [1:0]  mode;
        logic        print;
        logic [11:0] target;
        logic [11:0] applied;
        logic [11:0] measured;
        logic [15:0][7:0] duty_table;
        logic [7:0]  duty_compare_register;
        logic [3:0]  slot_idx;
        logic [7:0]  pwm_cnt;
        logic [3:0]  pre_cnt;
        logic        pwm;
        logic [17:0] acc;
        logic [8:0]  acc_cnt;
        logic [13:0] sum16;
        logic [4:0]  sum_cnt;
        logic [3:0]  line_cnt;
        logic [7:0]  sweep_code;
        logic [8:0]  sweep_cnt;
        logic        session;
        logic        send_req;
        logic [15:0] send_val;
        logic [2:0]  send_n;
        logic        send_lf;
        logic        tx_busy;
        logic [2:0]  tx_digits;
        logic [15:0] tx_val;
        logic        tx_lf;
        logic        tx_sep;
        logic [9:0]  tx_shift;
        logic [3:0]  tx_bits;
        logic [9:0]  baud_cnt;
        logic        ser;
        logic [1:0]  prev_mode;
    } state_t;

    state_t s_reg;
    state_t s_next;

    // comb helpers, kept at module level so the checks below can see them
    logic [11:0] wtgt;
    logic [11:0] rounded;
    logic        slot_end;
    logic        period_end;
    logic        correct;

    function automatic logic [7:0] hex_char(input logic [3:0] d);
        hex_char = (d < 4'hA) ? (8'h30 + {4'h0, d}) : (8'h37 + {4'h0, d});
    endfunction

    // pattern p: spread n extra periods evenly over 16
    // pattern zero flat
    function automatic logic dither_bit(input logic [3:0] n, input logic [3:0] slot);
        logic [7:0] a;
        logic [7:0] b;
        a = {4'h0, n} * ({4'h0, slot} + 8'h01);
        b = {4'h0, n} * {4'h0, slot};
        dither_bit = (a[7:4] != b[7:4]);
    endfunction

    function automatic logic [15:0][7:0] build_table(input logic [11:0] code);
        logic [15:0][7:0] t;
        t = '0;
        for (int i = 0; i < 16; i++) begin
            t[i] = code[11:4] + {7'h00, dither_bit(code[3:0], 4'(i))};
        end
        return t;
    endfunction

    // ---------------------------------------------
    // next state
    // ---------------------------------------------
    always_comb begin
        wtgt       = '0;
        rounded    = '0;
        correct    = 1'b0;
        s_next     = s_reg;
        s_next.send_req = 1'b0;

        // register access
        s_next.rdata = 32'h0000_0000;
        if (wr_i) begin
            unique case (addr_i)
                `OFS_CTRL: begin
                    s_next.mode  = wdata_i[`CTRL_MODE_LSB +: 2];
                    s_next.print = wdata_i[`CTRL_PRINT_BIT];
                end
                `OFS_TARGET: begin
                    wtgt = wdata_i[11:0];
                    s_next.target = (wdata_i[31:12] != 0 || wtgt > `CODE_MAX) ?
                                    `CODE_MAX : wtgt;
                end
                `OFS_APPLIED: begin
                    wtgt = wdata_i[11:0];
                    s_next.applied = (wtgt > `CODE_MAX) ? `CODE_MAX : wtgt;
                    s_next.duty_table = build_table(s_next.applied);
                end
                default: ;
            endcase
        end
        if (rd_i) begin
            unique case (addr_i)
                `OFS_CTRL:     s_next.rdata = {29'h0, s_reg.print, s_reg.mode};
                `OFS_TARGET:   s_next.rdata = {20'h0, s_reg.target};
                `OFS_APPLIED:  s_next.rdata = {20'h0, s_reg.applied};
                `OFS_MEASURED: s_next.rdata = {20'h0, s_reg.measured};
                default:       s_next.rdata = 32'h0000_0000;
            endcase
        end

        // pwm counter: 256 slots of PWM_SLOT_CYC cycles
        slot_end   = (s_reg.pre_cnt == 4'(`PWM_SLOT_CYC - 1));
        period_end = slot_end && (s_reg.pwm_cnt == 8'hFF);
        s_next.pre_cnt = slot_end ? 4'h0 : s_reg.pre_cnt + 4'h1;
        if (slot_end)
            s_next.pwm_cnt = s_reg.pwm_cnt + 8'h01;
        // high for duty slots of 256 only
        s_next.pwm = (s_next.pwm_cnt < s_reg.duty_compare_register);
        if (period_end) begin
            s_next.duty_compare_register = s_reg.duty_table[s_reg.slot_idx];
            s_next.slot_idx = s_reg.slot_idx + 4'h1;
        end

        // session start on mode change
        s_next.prev_mode = s_reg.mode;
        if (s_reg.mode != s_reg.prev_mode) begin
            s_next.acc = '0; s_next.acc_cnt = '0; s_next.sum16 = '0;
            s_next.sum_cnt = '0; s_next.line_cnt = '0;
            s_next.sweep_code = '0; s_next.sweep_cnt = '0;
            s_next.session = (s_reg.mode != MODE_IDLE) && s_reg.print;
            if (s_reg.mode == MODE_SWEEP)
                s_next.duty_table = build_table({8'h00, 4'h0});
        end else if (s_reg.session && !s_reg.tx_busy) begin
            s_next.session  = 1'b0;
            s_next.send_req = (s_reg.mode != MODE_SWEEP);
            s_next.send_val = {4'h0, s_reg.target};
            s_next.send_n   = 3'd3;
            s_next.send_lf  = 1'b1;
        end else if (sample_valid_i && s_reg.mode != MODE_IDLE) begin
            s_next.sum16   = s_reg.sum16 + {4'h0, filtered_feedback_input_i};
            s_next.sum_cnt = s_reg.sum_cnt + 5'd1;
            s_next.acc     = s_reg.acc + {8'h00, filtered_feedback_input_i};
            s_next.acc_cnt = s_reg.acc_cnt + 9'd1;
            if (s_next.sum_cnt == 5'(`OPEN_SAMPLES)) begin
                s_next.sum_cnt  = '0;
                s_next.line_cnt = s_reg.line_cnt + 4'h1;
                s_next.send_req = s_reg.print;
                s_next.send_val = (s_reg.mode == MODE_SWEEP) ? {2'b00, s_next.sum16} :
                                  {6'h00, s_next.sum16[13:4]} << 2;
                s_next.send_n   = (s_reg.mode == MODE_SWEEP) ? 3'd4 : 3'd3;
                s_next.send_lf  = (s_reg.line_cnt == 4'hF);
                // cleared only after the finished sum is taken
                s_next.sum16    = '0;
            end
            if (s_next.acc_cnt == 9'(`CLOSED_SAMPLES)) begin
                // round 18-bit sum down to 12 bits
                rounded = 12'((s_next.acc + 18'h0_0020) >> 6);
                if (s_next.acc > 18'h3_FFDF)
                    rounded = 12'hFFF;
                s_next.measured = rounded;
                correct = (s_reg.mode == MODE_CLOSED);
                s_next.acc_cnt = '0;
                s_next.acc     = '0;
            end
        end

        // closed-loop correction
        if (correct) begin
            // raise one step; ignore at top
            if (rounded < s_reg.target && s_reg.applied != `CODE_MAX)
                s_next.applied = s_reg.applied + 12'h001;
            // lower one step; ignore at zero
            else if (rounded > s_reg.target && s_reg.applied != `CODE_MIN)
                s_next.applied = s_reg.applied - 12'h001;
            s_next.duty_table = build_table(s_next.applied);
        end

        if (s_reg.mode == MODE_SWEEP && sample_valid_i && s_reg.mode == s_reg.prev_mode
            && !s_reg.session) begin
            s_next.sweep_cnt = s_reg.sweep_cnt + 9'd1;
            if (s_next.sweep_cnt == 9'(`SWEEP_HOLD)) begin
                s_next.sweep_cnt = '0;
                s_next.line_cnt  = '0;
                if (s_reg.sweep_code != `DUTY_MAX) begin
                    s_next.sweep_code = s_reg.sweep_code + 8'h01;
                    s_next.duty_table = build_table({s_next.sweep_code, 4'h0});
                end else begin
                    s_next.mode = MODE_IDLE;
                end
            end
        end

        // uart: hex digits then separator, 8N1
        if (s_reg.tx_busy) begin
            s_next.baud_cnt = s_reg.baud_cnt + 10'd1;
            if (s_reg.baud_cnt == 10'(`BAUD_CYC - 1)) begin
                s_next.baud_cnt = '0;
                s_next.ser      = s_reg.tx_shift[0];
                s_next.tx_shift = {1'b1, s_reg.tx_shift[9:1]};
                s_next.tx_bits  = s_reg.tx_bits - 4'h1;
                if (s_reg.tx_bits == 4'h0) begin
                    s_next.ser = 1'b1;
                    if (s_reg.tx_digits != 3'd0) begin
                        s_next.tx_digits = s_reg.tx_digits - 3'd1;
                        s_next.tx_shift  = {1'b1, hex_char(s_reg.tx_val[15:12]), 1'b0};
                        s_next.tx_val    = s_reg.tx_val << 4;
                        s_next.tx_bits   = 4'd9;
                    end else if (s_reg.tx_sep) begin
                        // separator closes every value
                        s_next.tx_sep   = 1'b0;
                        s_next.tx_shift = {1'b1, (s_reg.tx_lf ? 8'h0A : 8'h2C), 1'b0};
                        s_next.tx_bits  = 4'd9;
                    end else begin
                        s_next.tx_busy = 1'b0;
                    end
                end
            end
        end else if (s_reg.send_req) begin
            s_next.tx_busy   = 1'b1;
            s_next.tx_val    = s_reg.send_val << (4 * (3'd4 - s_reg.send_n));
            s_next.tx_digits = s_reg.send_n;
            s_next.tx_lf     = s_reg.send_lf;
            s_next.tx_shift  = {1'b1, (s_reg.send_lf ? 8'h0A : 8'h2C), 1'b0};
            s_next.tx_bits   = 4'h0;
            s_next.tx_sep    = 1'b1;
            s_next.baud_cnt  = 10'(`BAUD_CYC - 1);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_reg <= '0;
            s_reg.ser <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rdata_o               = s_reg.rdata;
    assign pwm_output_pin_o      = s_reg.pwm;
    assign monitor_serial_port_o = s_reg.ser;

    // ---------------------------------------------
    // checks
    // ---------------------------------------------
    AST_TARGET_MAX: assert property (@(posedge clk_i) disable iff (rst_i)
        s_reg.target <= `CODE_MAX) else $error("target above limit");
    AST_APPLIED_MAX: assert property (@(posedge clk_i) disable iff (rst_i)
        s_reg.applied <= `CODE_MAX) else $error("applied above limit");
    AST_LAST_SLOT_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
        s_reg.pwm_cnt == 8'hFF |-> !pwm_output_pin_o) else $error("pin high in last slot");
    AST_STEP_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
        correct && !wr_i |=> (s_reg.applied - $past(s_reg.applied) <= 12'h001) ||
        ($past(s_reg.applied) - s_reg.applied <= 12'h001)) else $error("step not one");
    AST_EQUAL_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        correct && !wr_i && rounded == s_reg.target |=> $stable(s_reg.applied))
        else $error("code changed on match");
    AST_MIN_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        correct && !wr_i && s_reg.applied == 12'h000 |=> s_reg.applied == 12'h000)
        else $error("decrease below zero");
    AST_IDLE_LINE: assert property (@(posedge clk_i) disable iff (rst_i)
        !s_reg.tx_busy |=> monitor_serial_port_o) else $error("line not idle");
    AST_OPEN_NOCORR: assert property (@(posedge clk_i) disable iff (rst_i)
        s_reg.mode == MODE_OPEN && !wr_i |=> $stable(s_reg.applied))
        else $error("open loop corrected");
    COV_CORRECT: cover property (@(posedge clk_i) correct);
    COV_SEND: cover property (@(posedge clk_i) s_reg.send_req);
    COV_SWEEP_END: cover property (@(posedge clk_i) s_reg.sweep_code == 8'hFF);
endmodule

//--- dv/rc_adc_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// filter and converter stand-in
// ----------------------------------------
module rc_adc_model (
    // clock
    input  wire logic       clk_i,
    // settled filter level, set by the bench
    input  wire logic [9:0] level_i,
    // conversion result
    output logic      [9:0] sample_o,
    output logic            valid_o
);
    logic [3:0] gap_reg;

    initial begin
        gap_reg = 4'h0;
        valid_o = 1'b0;
        sample_o = 10'h000;
    end

    // one conversion every 16 clocks; data is scrambled outside
    // the valid cycle so a late capture cannot pass by luck
    always @(posedge clk_i) begin
        gap_reg <= gap_reg + 4'h1;
        valid_o <= (gap_reg == 4'hF);
        sample_o <= (gap_reg == 4'hF) ? level_i : ~sample_o;
    end
endmodule

//--- dv/testbench.sv
`timescale 1ns/1ps
`include "dither_dac_regs.svh"
module testbench;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic        clk_i;
    logic        rst_i;
    logic [3:0]  addr_i;
    logic [31:0] wdata_i;
    logic        wr_i;
    logic        rd_i;
    logic [31:0] rdata_o;
    logic [9:0]  level;
    logic [9:0]  sample;
    logic        sample_valid;
    logic        pwm;
    logic        ser;
    logic        cnt_en;
    logic [31:0] highs;
    logic [31:0] d;
    logic [7:0]  ch;
    int          i;
    int          err_count;
    int          comparisons;

    dither_dac dut (
        .clk_i                     (clk_i),
        .rst_i                     (rst_i),
        .addr_i                    (addr_i),
        .wdata_i                   (wdata_i),
        .wr_i                      (wr_i),
        .rd_i                      (rd_i),
        .rdata_o                   (rdata_o),
        .filtered_feedback_input_i (sample),
        .sample_valid_i            (sample_valid),
        .pwm_output_pin_o          (pwm),
        .monitor_serial_port_o     (ser)
    );

    rc_adc_model adc (
        .clk_i    (clk_i),
        .level_i  (level),
        .sample_o (sample),
        .valid_o  (sample_valid)
    );

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // high time over 16 whole periods is phase independent
    always @(posedge clk_i) begin
        if (!cnt_en) begin
            highs <= 32'h0000_0000;
        end else if (pwm === 1'b1) begin
            highs <= highs + 32'h0000_0001;
        end
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
        @(posedge clk_i);
    endtask

    // a count over fewer than 16 periods is only valid for undithered codes
    function automatic logic [31:0] high_cycles(input logic [11:0] code, input int periods);
        high_cycles = `PWM_SLOT_CYC * (periods * code[11:4] + (periods / 16) * code[3:0]);
    endfunction

    // whole periods make the count independent of where it starts
    task automatic high_check(input int periods, input logic [31:0] exp);
        cnt_en <= 1'b1;
        repeat (periods * 256 * `PWM_SLOT_CYC) @(posedge clk_i);
        cnt_en <= 1'b0;
        #1;
        check(highs, exp);
        @(posedge clk_i);
    endtask

    // seed, target and level, then one correction interval
    task automatic loop_case(input logic [11:0] seed, input logic [11:0] tgt,
                             input logic [9:0] lvl, input logic [11:0] exp,
                             input int periods);
        wr(`OFS_CTRL, 32'h0000_0000);
        wr(`OFS_APPLIED, {20'h0_0000, seed});
        wr(`OFS_TARGET, {20'h0_0000, tgt});
        level <= lvl;
        wr(`OFS_CTRL, 32'h0000_0001);
        repeat (300 * 16) @(posedge clk_i);
        rd(`OFS_MEASURED, d);
        check(d, {20'h0_0000, lvl, 2'b00});
        rd(`OFS_APPLIED, d);
        check(d, {20'h0_0000, exp});
        if (periods > 0) begin
            high_check(periods, high_cycles(exp, periods));
        end
    endtask

    task automatic tally_and_finish;
        if (err_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (90000) @(posedge clk_i);
        err_count++;
        tally_and_finish();
    end

    initial begin
        rst_i = 1'b1;
        addr_i = 4'h0;
        wdata_i = 32'h0000_0000;
        wr_i = 1'b0;
        rd_i = 1'b0;
        level = 10'h000;
        cnt_en = 1'b0;
        err_count = 0;
        comparisons = 0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (i = 0; i < 4; i++) begin
            rd(4'(i * 4), d);
            check(d, 32'h0000_0000);
        end
        // unmapped and read-only places ignore writes
        wr(4'h6, 32'h0000_0ABC);
        wr(`OFS_MEASURED, 32'h0000_0555);
        rd(4'h6, d);
        check(d, 32'h0000_0000);
        rd(`OFS_MEASURED, d);
        check(d, 32'h0000_0000);
        wr(`OFS_TARGET, 32'h0000_0FFF);
        rd(`OFS_TARGET, d);
        check(d, 32'h0000_0FF0);
        loop_case(12'hFE4, 12'hFE4, 10'h3F9, 12'hFE4, 16);
        loop_case(12'hFF0, 12'hFF0, 10'h3FB, 12'hFF0, 1);
        loop_case(12'h3FF, 12'h400, 10'h0FF, 12'h400, 0);
        loop_case(12'h400, 12'h3FC, 10'h101, 12'h3FF, 0);
        loop_case(12'h000, 12'h000, 10'h001, 12'h000, 0);
        // open monitoring: first character is the target's top digit
        wr(`OFS_CTRL, 32'h0000_0000);
        wr(`OFS_TARGET, 32'h0000_0D1B);
        wr(`OFS_APPLIED, 32'h0000_0123);
        level <= 10'h000;
        wr(`OFS_CTRL, 32'h0000_0006);
        i = 0;
        while (ser !== 1'b0 && i < 30000) begin
            @(posedge clk_i);
            i++;
        end
        repeat (`BAUD_CYC / 2) @(posedge clk_i);
        check({31'h0000_0000, ser}, 32'h0000_0000);
        for (i = 0; i < 8; i++) begin
            repeat (`BAUD_CYC) @(posedge clk_i);
            ch[i] = ser;
        end
        check({24'h00_0000, ch}, 32'h0000_0044);
        repeat (`BAUD_CYC) @(posedge clk_i);
        check({31'h0000_0000, ser}, 32'h0000_0001);
        rd(`OFS_APPLIED, d);
        check(d, 32'h0000_0123);
        // sweep: after 256 conversions the undithered duty steps to 0x01
        wr(`OFS_CTRL, 32'h0000_0003);
        repeat (256 * 16 + 1600) @(posedge clk_i);
        high_check(1, `PWM_SLOT_CYC);
        tally_and_finish();
    end
endmodule
